// ### hw/ifd_decoder.sv
// instruction field decoder with ahb-lite register access
//
// Local design decisions: the AHB-Lite register port and the address map.
`default_nettype none

module ifd_decoder
  import ifd_pkg::*;
#(
  parameter int unsigned ADDR_W = 32
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // instruction from fetch
  input  wire logic              fetch_valid,
  input  wire logic [31:0]       fetch_word,
  // decoded outputs to execution
  output ifd_dec_t               dec,
  output logic      [31:0]       condition_field_register,
  output logic                   trap_taken
);

  if (ADDR_W < 8) begin : g_addr_w_chk
    $error("ifd_decoder: ADDR_W must be at least 8");
  end

  // ****************************************************************
  // bus phase tracking
  // ****************************************************************
  typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_RWAIT, PH_RDONE} ifd_phase_t;

  ifd_phase_t  phase_ff;
  ifd_phase_t  nxt_phase;
  logic [7:0]  addr_ff;
  logic [31:0] hrdata_ff;
  logic        accept;

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [31:0] instr_ff;
  logic [31:0] opa_ff;
  logic [31:0] opb_ff;
  logic [4:0]  fpst_ff;
  logic [31:0] cr_ff;
  ifd_dec_t    dec_ff;
  logic        trap_ff;

  ifd_dec_t    dec_now;
  logic        trap_now;
  logic        wr_now;
  logic        cmd_fx;
  logic        cmd_fp;

  // ****************************************************************
  // mask generation
  // ****************************************************************
  // wrap form: position p is one when p>=start or p<=stop; with start<=stop
  // only the inner run is kept, which also covers start = stop+1 as all ones
  function automatic logic [31:0] rotate_mask_of(input logic [4:0] mstart,
                                                 input logic [4:0] mstop);
    logic [31:0] m;
    logic [5:0]  stop1;
    m     = 32'h0000_0000;
    stop1 = {1'b0, mstop} + 6'h01;
    for (int p = 0; p < 32; p++) begin
      if ({1'b0, mstart} < stop1) begin
        m[31-p] = (5'(p) >= mstart) && (5'(p) <= mstop);
      end else if ({1'b0, mstart} == stop1) begin
        m[31-p] = 1'b1;
      end else begin
        m[31-p] = !((5'(p) > mstop) && (5'(p) < mstart));
      end
    end
    return m;
  endfunction

  // ****************************************************************
  // special register select
  // ****************************************************************
  function automatic ifd_spr_t spr_of(input logic [4:0] code);
    ifd_spr_t s;
    s = SPR_NONE;
    unique case (code)
      IFD_SPR_MQ:     s = SPR_MULTIPLY_QUOTIENT;
      IFD_SPR_XER:    s = SPR_FIXED_POINT_EXCEPTION;
      IFD_SPR_RD_CU:  s = SPR_CLOCK_UPPER_RD;
      IFD_SPR_RD_CL:  s = SPR_CLOCK_LOWER_RD;
      IFD_SPR_RD_DEC: s = SPR_COUNTDOWN_RD;
      IFD_SPR_LR:     s = SPR_LINK;
      IFD_SPR_CTR:    s = SPR_COUNT;
      IFD_SPR_WR_CU:  s = SPR_CLOCK_UPPER_WR;
      IFD_SPR_WR_CL:  s = SPR_CLOCK_LOWER_WR;
      IFD_SPR_WR_DEC: s = SPR_COUNTDOWN_WR;
      IFD_SPR_SRR0:   s = SPR_SAVE_RESTORE_FIRST;
      IFD_SPR_SRR1:   s = SPR_SAVE_RESTORE_SECOND;
      default:        s = SPR_NONE;
    endcase
    return s;
  endfunction

  // ****************************************************************
  // field decode of the held word
  // ****************************************************************
  always_comb begin
    logic [6:0] system_call_vector_index;
    system_call_vector_index = 7'(ifd_field(instr_ff, IFD_POS_LEV_F, IFD_POS_LEV_L));
    dec_now = '0;
    dec_now.primary_opcode          = 6'(ifd_field(instr_ff, IFD_POS_OPC_F,
                                                   IFD_POS_OPC_L));
    dec_now.target_gpr_index        = 5'(ifd_field(instr_ff, IFD_POS_RT_F,
                                                   IFD_POS_RT_L));
    dec_now.trap_condition_mask     = dec_now.target_gpr_index;
    dec_now.first_source_gpr_index  = 5'(ifd_field(instr_ff, IFD_POS_RA_F,
                                                   IFD_POS_RA_L));
    dec_now.special_register_select = dec_now.first_source_gpr_index;
    dec_now.spr_target              = spr_of(dec_now.special_register_select);
    dec_now.second_source_gpr_index = 5'(ifd_field(instr_ff, IFD_POS_RB_F,
                                                   IFD_POS_RB_L));
    dec_now.string_byte_count       = dec_now.second_source_gpr_index;
    dec_now.rotate_amount_field     = dec_now.second_source_gpr_index;
    dec_now.mask_begin_index        = 5'(ifd_field(instr_ff, IFD_POS_MB_F,
                                                   IFD_POS_MB_L));
    dec_now.mask_end_index          = 5'(ifd_field(instr_ff, IFD_POS_ME_F,
                                                   IFD_POS_ME_L));
    dec_now.extended_opcode         = dec_now.mask_end_index;
    dec_now.ds_extended_opcode      = 2'(ifd_field(instr_ff, IFD_POS_DSXO_F,
                                                   IFD_POS_DSXO_L));
    dec_now.signed_immediate        = 16'(ifd_field(instr_ff, IFD_POS_IMM_F,
                                                    IFD_POS_IMM_L));
    dec_now.unsigned_immediate      = dec_now.signed_immediate;
    dec_now.rotate_mask             = rotate_mask_of(dec_now.mask_begin_index,
                                                     dec_now.mask_end_index);
    dec_now.record_bit              = instr_ff[31-IFD_POS_RC];
    dec_now.ov_inhibit              = instr_ff[31-IFD_POS_OE];
    dec_now.system_call_absolute_flag = instr_ff[31-IFD_POS_SA];
    if (dec_now.system_call_absolute_flag) begin
      dec_now.svc_handler_addr = IFD_SVC_ABS_ADDR;
    end else begin
      dec_now.svc_handler_addr = {19'h0_0000, 1'b1, system_call_vector_index, IFD_SVC_LOW_ZERO};
    end
  end

  // ****************************************************************
  // trap evaluation on the two operand registers
  // ****************************************************************
  always_comb begin
    logic [4:0] hit;
    hit[4] = $signed(opa_ff) < $signed(opb_ff);
    hit[3] = $signed(opa_ff) > $signed(opb_ff);
    hit[2] = opa_ff == opb_ff;
    hit[1] = opa_ff < opb_ff;
    hit[0] = opa_ff > opb_ff;
    trap_now = |(hit & dec_now.trap_condition_mask);
  end

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  // reads take one wait state so the read word is fresh even right
  // after a write to the same register
  assign accept    = hsel && htrans[1] && hready;
  assign hreadyout = (phase_ff != PH_RWAIT);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign wr_now    = (phase_ff == PH_WRITE);
  assign cmd_fx    = wr_now && (addr_ff == IFD_OFS_CMD) && hwdata[IFD_CMD_FX_BIT];
  assign cmd_fp    = wr_now && (addr_ff == IFD_OFS_CMD) && hwdata[IFD_CMD_FP_BIT];

  always_comb begin
    nxt_phase = PH_IDLE;
    unique case (phase_ff)
      PH_RWAIT: nxt_phase = PH_RDONE;
      PH_IDLE, PH_WRITE, PH_RDONE: begin
        if (accept) begin
          nxt_phase = hwrite ? PH_WRITE : PH_RWAIT;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_ff <= PH_IDLE;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_ff <= 8'h00;
    end else if (accept && (phase_ff != PH_RWAIT)) begin
      addr_ff <= {haddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (phase_ff == PH_RWAIT) begin
      unique case (addr_ff)
        IFD_OFS_INSTR:  hrdata_ff <= instr_ff;
        IFD_OFS_FIELDS: hrdata_ff <= {1'b0, dec_now.primary_opcode, 1'b0,
                                      dec_now.target_gpr_index,
                                      dec_now.first_source_gpr_index,
                                      dec_now.second_source_gpr_index,
                                      dec_now.extended_opcode,
                                      dec_now.ds_extended_opcode,
                                      dec_now.record_bit,
                                      dec_now.ov_inhibit};
        IFD_OFS_MASK:   hrdata_ff <= dec_now.rotate_mask;
        IFD_OFS_IMM:    hrdata_ff <= {{16{dec_now.signed_immediate[15]}},
                                      dec_now.signed_immediate};
        IFD_OFS_SVC:    hrdata_ff <= dec_now.svc_handler_addr;
        IFD_OFS_MISC:   hrdata_ff <= {18'h0_0000, trap_now,
                                      dec_now.system_call_absolute_flag,
                                      dec_now.spr_target, 4'h0,
                                      dec_now.trap_condition_mask[4:1]};
        IFD_OFS_OPA:    hrdata_ff <= opa_ff;
        IFD_OFS_OPB:    hrdata_ff <= opb_ff;
        IFD_OFS_FPST:   hrdata_ff <= {27'h000_0000, fpst_ff};
        IFD_OFS_CR:     hrdata_ff <= cr_ff;
        default:        hrdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // instruction word: fetch has priority over a bus write
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      instr_ff <= IFD_RST_WORD;
    end else if (fetch_valid) begin
      instr_ff <= fetch_word;
    end else if (wr_now && (addr_ff == IFD_OFS_INSTR)) begin
      instr_ff <= hwdata;
    end
  end

  // ****************************************************************
  // operand and status registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      opa_ff  <= 32'h0000_0000;
      opb_ff  <= 32'h0000_0000;
      fpst_ff <= 5'h00;
    end else if (wr_now) begin
      if (addr_ff == IFD_OFS_OPA) begin
        opa_ff <= hwdata;
      end
      if (addr_ff == IFD_OFS_OPB) begin
        opb_ff <= hwdata;
      end
      if (addr_ff == IFD_OFS_FPST) begin
        fpst_ff <= hwdata[4:0];
      end
    end
  end

  // ****************************************************************
  // condition register update
  // ****************************************************************
  // field 0 sits in the top nibble because bit 0 is the msb
  always_ff @(posedge clk) begin
    if (srst) begin
      cr_ff <= 32'h0000_0000;
    end else if (dec_now.record_bit) begin
      if (cmd_fx) begin
        cr_ff[31] <= opa_ff[31];
        cr_ff[30] <= !opa_ff[31] && (opa_ff != 32'h0000_0000);
        cr_ff[29] <= (opa_ff == 32'h0000_0000);
        cr_ff[28] <= fpst_ff[IFD_FPST_SO];
      end
      if (cmd_fp) begin
        cr_ff[27:24] <= fpst_ff[3:0];
      end
    end
  end

  // ****************************************************************
  // registered outputs to execution units
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      dec_ff  <= '0;
      trap_ff <= 1'b0;
    end else begin
      dec_ff  <= dec_now;
      trap_ff <= trap_now;
    end
  end

  assign dec                      = dec_ff;
  assign condition_field_register = cr_ff;
  assign trap_taken               = trap_ff;

  // hsize is accepted but ignored; every transfer is served as a whole word
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[1:0]};

endmodule

`default_nettype wire

// ### pkg/ifd_pkg.sv
// constants, types and field helpers for the instruction field decoder
`default_nettype none

package ifd_pkg;

  // ****************************************************************
  // register map (byte offsets, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] IFD_OFS_INSTR  = 8'h00;
  localparam logic [7:0] IFD_OFS_FIELDS = 8'h04;
  localparam logic [7:0] IFD_OFS_MASK   = 8'h08;
  localparam logic [7:0] IFD_OFS_IMM    = 8'h0c;
  localparam logic [7:0] IFD_OFS_SVC    = 8'h10;
  localparam logic [7:0] IFD_OFS_MISC   = 8'h14;
  localparam logic [7:0] IFD_OFS_OPA    = 8'h18;
  localparam logic [7:0] IFD_OFS_OPB    = 8'h1c;
  localparam logic [7:0] IFD_OFS_FPST   = 8'h20;
  localparam logic [7:0] IFD_OFS_CR     = 8'h24;
  localparam logic [7:0] IFD_OFS_CMD    = 8'h28;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] IFD_RST_WORD = 32'h0000_0000;

  // ****************************************************************
  // instruction field positions, bit 0 is the msb of the word
  // ****************************************************************
  localparam int IFD_POS_OPC_F  = 0;
  localparam int IFD_POS_OPC_L  = 5;
  localparam int IFD_POS_RT_F   = 6;
  localparam int IFD_POS_RT_L   = 10;
  localparam int IFD_POS_RA_F   = 11;
  localparam int IFD_POS_RA_L   = 15;
  localparam int IFD_POS_RB_F   = 16;
  localparam int IFD_POS_RB_L   = 20;
  localparam int IFD_POS_IMM_F  = 16;
  localparam int IFD_POS_IMM_L  = 31;
  localparam int IFD_POS_LEV_F  = 20;
  localparam int IFD_POS_LEV_L  = 26;
  localparam int IFD_POS_MB_F   = 21;
  localparam int IFD_POS_MB_L   = 25;
  localparam int IFD_POS_ME_F   = 26;
  localparam int IFD_POS_ME_L   = 30;
  localparam int IFD_POS_OE     = 21;
  localparam int IFD_POS_SA     = 30;
  localparam int IFD_POS_RC     = 31;
  localparam int IFD_POS_DSXO_F = 30;
  localparam int IFD_POS_DSXO_L = 31;

  // ****************************************************************
  // system call vectors
  // ****************************************************************
  localparam logic [31:0] IFD_SVC_ABS_ADDR = 32'h0000_1fe0;
  localparam logic [4:0]  IFD_SVC_LOW_ZERO = 5'h00;

  // ****************************************************************
  // command register bits, fpst summary bit position
  // ****************************************************************
  localparam int IFD_CMD_FX_BIT = 0;
  localparam int IFD_CMD_FP_BIT = 1;
  localparam int IFD_FPST_SO    = 4;

  // ****************************************************************
  // special register select codes
  // ****************************************************************
  localparam logic [4:0] IFD_SPR_MQ     = 5'h00;
  localparam logic [4:0] IFD_SPR_XER    = 5'h01;
  localparam logic [4:0] IFD_SPR_RD_CU  = 5'h04;
  localparam logic [4:0] IFD_SPR_RD_CL  = 5'h05;
  localparam logic [4:0] IFD_SPR_RD_DEC = 5'h06;
  localparam logic [4:0] IFD_SPR_LR     = 5'h08;
  localparam logic [4:0] IFD_SPR_CTR    = 5'h09;
  localparam logic [4:0] IFD_SPR_WR_CU  = 5'h14;
  localparam logic [4:0] IFD_SPR_WR_CL  = 5'h15;
  localparam logic [4:0] IFD_SPR_WR_DEC = 5'h16;
  localparam logic [4:0] IFD_SPR_SRR0   = 5'h1a;
  localparam logic [4:0] IFD_SPR_SRR1   = 5'h1b;

  typedef enum logic [3:0] {
    SPR_NONE,
    SPR_MULTIPLY_QUOTIENT,
    SPR_FIXED_POINT_EXCEPTION,
    SPR_CLOCK_UPPER_RD,
    SPR_CLOCK_LOWER_RD,
    SPR_COUNTDOWN_RD,
    SPR_LINK,
    SPR_COUNT,
    SPR_CLOCK_UPPER_WR,
    SPR_CLOCK_LOWER_WR,
    SPR_COUNTDOWN_WR,
    SPR_SAVE_RESTORE_FIRST,
    SPR_SAVE_RESTORE_SECOND
  } ifd_spr_t;

  // decoded view of one instruction word
  typedef struct packed {
    logic [5:0]  primary_opcode;
    logic [4:0]  target_gpr_index;
    logic [4:0]  first_source_gpr_index;
    logic [4:0]  second_source_gpr_index;
    logic [4:0]  mask_begin_index;
    logic [4:0]  mask_end_index;
    logic [4:0]  string_byte_count;
    logic [4:0]  rotate_amount_field;
    logic [4:0]  extended_opcode;
    logic [1:0]  ds_extended_opcode;
    logic [4:0]  trap_condition_mask;
    logic [4:0]  special_register_select;
    ifd_spr_t    spr_target;
    logic [15:0] signed_immediate;
    logic [15:0] unsigned_immediate;
    logic [31:0] rotate_mask;
    logic [31:0] svc_handler_addr;
    logic        record_bit;
    logic        ov_inhibit;
    logic        system_call_absolute_flag;
  } ifd_dec_t;

  // extracts bits first..last of a word numbered from the msb
  function automatic logic [31:0] ifd_field(input logic [31:0] w, input int first,
                                            input int last);
    logic [31:0] sh;
    logic [31:0] msk;
    sh  = w >> (31 - last);
    msk = (32'h0000_0001 << (last - first + 1)) - 32'h0000_0001;
    return sh & msk;
  endfunction

endpackage

`default_nettype wire

// ### tb/ifd_decoder_props.sv
// concurrent checks on the instruction field decoder ports
`default_nettype none

module ifd_decoder_props
  import ifd_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // register bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // fetch and decode
  input wire logic        fetch_valid,
  input wire logic [31:0] fetch_word,
  input wire ifd_dec_t    dec,
  input wire logic [31:0] condition_field_register
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // sequences and helpers
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // a loaded word is decoded two edges after its fetch strobe
  sequence s_load;
    fetch_valid ##2 1'b1;
  endsequence
  sequence s_rd_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence

  function automatic ifd_spr_t spr_of(input logic [4:0] c);
    case (c)
      IFD_SPR_MQ:     return SPR_MULTIPLY_QUOTIENT;
      IFD_SPR_XER:    return SPR_FIXED_POINT_EXCEPTION;
      IFD_SPR_RD_CU:  return SPR_CLOCK_UPPER_RD;
      IFD_SPR_RD_CL:  return SPR_CLOCK_LOWER_RD;
      IFD_SPR_RD_DEC: return SPR_COUNTDOWN_RD;
      IFD_SPR_LR:     return SPR_LINK;
      IFD_SPR_CTR:    return SPR_COUNT;
      IFD_SPR_WR_CU:  return SPR_CLOCK_UPPER_WR;
      IFD_SPR_WR_CL:  return SPR_CLOCK_LOWER_WR;
      IFD_SPR_WR_DEC: return SPR_COUNTDOWN_WR;
      IFD_SPR_SRR0:   return SPR_SAVE_RESTORE_FIRST;
      IFD_SPR_SRR1:   return SPR_SAVE_RESTORE_SECOND;
      default:        return SPR_NONE;
    endcase
  endfunction

  // ****************************************************************
  // assertions
  // ****************************************************************
  opcode_field_a: assert property (s_load |->
    dec.primary_opcode == $past(fetch_word[31:26], 2)) else $error("opcode field wrong");
  gpr_index_a: assert property (s_load |-> {dec.target_gpr_index,
    dec.first_source_gpr_index, dec.second_source_gpr_index} == $past(fetch_word[25:11], 2))
    else $error("register index fields wrong");
  mask_index_a: assert property (s_load |->
    {dec.mask_begin_index, dec.mask_end_index} == $past(fetch_word[10:1], 2))
    else $error("mask index fields wrong");
  mask_shape_a: assert property (s_load |->
    dec.rotate_mask[~dec.mask_begin_index] && dec.rotate_mask[~dec.mask_end_index]
    && (dec.mask_begin_index != dec.mask_end_index + 5'd1 || &dec.rotate_mask)
    && (dec.mask_begin_index != dec.mask_end_index + 5'd2
        || !dec.rotate_mask[~(dec.mask_end_index + 5'd1)])) else $error("rotate mask wrong");
  count_shift_a: assert property (s_load |->
    dec.string_byte_count == $past(fetch_word[15:11], 2)
    && dec.rotate_amount_field == $past(fetch_word[15:11], 2)) else $error("count wrong");
  imm_field_a: assert property (s_load |->
    dec.signed_immediate == $past(fetch_word[15:0], 2)
    && dec.unsigned_immediate == $past(fetch_word[15:0], 2)) else $error("immediate wrong");
  flag_bits_a: assert property (s_load |->
    {dec.ov_inhibit, dec.system_call_absolute_flag, dec.record_bit}
    == {$past(fetch_word[10], 2), $past(fetch_word[1:0], 2)}) else $error("flag bits wrong");
  svc_addr_a: assert property (s_load |-> dec.svc_handler_addr ==
    ($past(fetch_word[1], 2) ? 32'h0000_1fe0 : {19'h0, 1'b1, $past(fetch_word[11:5], 2), 5'h00}))
    else $error("handler address wrong");
  xo_fields_a: assert property (s_load |->
    dec.extended_opcode == $past(fetch_word[5:1], 2)
    && dec.ds_extended_opcode == $past(fetch_word[1:0], 2)) else $error("extended opcode wrong");
  trap_mask_a: assert property (s_load |->
    dec.trap_condition_mask == $past(fetch_word[25:21], 2)) else $error("trap mask wrong");
  spr_map_a: assert property (s_load |->
    dec.special_register_select == $past(fetch_word[20:16], 2)
    && dec.spr_target == spr_of($past(fetch_word[20:16], 2))) else $error("select map wrong");
  cr_hold_a: assert property ($changed(condition_field_register) |->
    $past(dec.record_bit)) else $error("condition register changed without record bit");
  rd_wait_a: assert property (s_rd_taken |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
endmodule

bind ifd_decoder ifd_decoder_props ifd_decoder_props_inst (
  .clk(clk), .srst(srst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
  .dec(dec), .condition_field_register(condition_field_register)
);

`default_nettype wire

// ### tb/ifd_fetch_model.sv
// fetch unit model feeding instruction words to the decoder
`default_nettype none

module ifd_fetch_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // requests from the bench
  input  wire logic        issue,
  input  wire logic [31:0] issue_word,
  // fetch port
  output var  logic        fetch_valid = 1'b0,
  output var  logic [31:0] fetch_word = 32'h0000_0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // word launch
  // ****************************************************************
  // word is inverted between loads so a stale word is never mistaken for a load
  always_ff @(posedge clk) begin
    if (srst) begin
      fetch_valid <= 1'b0;
      fetch_word  <= 32'h0000_0000;
    end else begin
      fetch_valid <= issue;
      fetch_word  <= issue ? issue_word : ~fetch_word;
    end
  end
endmodule

`default_nettype wire

// ### tb/tb_ifd_decoder.sv
// self-checking bench for the instruction field decoder
`default_nettype none

module tb_ifd_decoder
  import ifd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // signals and tables
  // ****************************************************************
  logic        clk, srst, hsel, hwrite, hready, hreadyout, hresp, issue, fetch_valid;
  logic        trap_taken, rd_ph = 1'b0;
  logic [1:0]  htrans, fv_d = 2'b00;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, issue_word, fetch_word, cfr, rng, dw, sv;
  ifd_dec_t    dec;
  int          error_cnt, n_tests;
  logic [31:0] rdq [$];
  logic [31:0] decq [$];
  logic [9:0]  mt [8] = '{10'h01f, 10'h0a5, 10'h0c5, 10'h143, 10'h3e0, 10'h000, 10'h3ff, 10'h020};
  logic [63:0] op [3] = '{64'hffff_ffff_0000_0001, 64'h5_0000_0005, 64'h1_ffff_ffff};
  logic [4:0]  tv [3] = '{5'h11, 5'h04, 5'h0a};

  assign hready = hreadyout;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ifd_decoder ifd_decoder_inst (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fetch_valid(fetch_valid), .fetch_word(fetch_word), .dec(dec),
    .condition_field_register(cfr), .trap_taken(trap_taken)
  );
  ifd_fetch_model ifd_fetch_model_inst (
    .clk(clk), .srst(srst), .issue(issue), .issue_word(issue_word),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] nxt(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [31:0] mask_of(input int mb, input int me);
    for (int p = 0; p < 32; p++)
      mask_of[31-p] = (mb <= me) ? (p >= mb && p <= me) : !(p > me && p < mb);
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rdq.push_back(exp);
    bus(a, 1'b0, rng);
  endtask
  // strobe stays up so back-to-back loads need no gap
  task automatic fetch(input logic [31:0] w);
    decq.push_back(w);
    issue      <= 1'b1;
    issue_word <= w;
    @(posedge clk);
  endtask
  task automatic load(input logic [31:0] w);
    fetch(w);
    issue <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // ****************************************************************
  // result watcher
  // ****************************************************************
  always @(posedge clk) begin
    if (rd_ph && hreadyout === 1'b1)
      check("hrdata", rdq.pop_front(), hrdata);
    if (hreadyout === 1'b1)
      rd_ph <= hsel && htrans[1] && !hwrite;
    fv_d <= {fv_d[0], fetch_valid};
    if (fv_d[1]) begin
      dw = decq.pop_front();
      sv = dw[1] ? 32'h0000_1fe0 : {19'h0, 1'b1, dw[11:5], 5'h00};
      check("rotate_mask", mask_of(dw[10:6], dw[5:1]), dec.rotate_mask);
      check("svc_addr", sv, dec.svc_handler_addr);
      check("immediate", {16'h0, dw[15:0]}, {16'h0, dec.unsigned_immediate});
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {srst, hsel, hwrite, issue} = 4'b1100;
    {htrans, hsize} = 5'h02;
    {haddr, hwdata, issue_word} = '0;
    rng = 32'heafc4a07;
    error_cnt = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(IFD_OFS_INSTR, 32'h0);
    rd(IFD_OFS_MASK, 32'h8000_0000);
    rd(IFD_OFS_SVC, 32'h0000_1000);
    rd(8'h3c, 32'h0);
    foreach (mt[i]) begin
      rng = nxt(rng);
      fetch({rng[31:11], mt[i], rng[0]});
    end
    for (int i = 0; i < 64; i++) begin
      rng = nxt(rng);
      fetch({rng[31:21], i[4:0], rng[15:0]});
    end
    issue <= 1'b0;
    repeat (3) @(posedge clk);
    bus(IFD_OFS_INSTR, 1'b1, 32'h7c00_00c2);
    rd(IFD_OFS_INSTR, 32'h7c00_00c2);
    bus(IFD_OFS_MASK, 1'b1, 32'h0);
    rd(IFD_OFS_MASK, 32'hdfff_ffff);
    rd(IFD_OFS_SVC, 32'h0000_1fe0);
    foreach (op[j]) begin
      bus(IFD_OFS_OPA, 1'b1, op[j][63:32]);
      bus(IFD_OFS_OPB, 1'b1, op[j][31:0]);
      for (int k = 0; k < 5; k++) begin
        load({6'h03, 5'h10 >> k, 21'h0});
        @(posedge clk);
        check("trap_taken", {31'h0, tv[j][4-k]}, {31'h0, trap_taken});
      end
    end
    bus(IFD_OFS_OPA, 1'b1, 32'h8000_0000);
    bus(IFD_OFS_FPST, 1'b1, 32'h0000_001a);
    load(32'h7c00_0000);
    bus(IFD_OFS_CMD, 1'b1, 32'h3);
    rd(IFD_OFS_CR, 32'h0);
    load(32'h7c00_0001);
    bus(IFD_OFS_CMD, 1'b1, 32'h1);
    rd(IFD_OFS_CR, 32'h9000_0000);
    bus(IFD_OFS_FPST, 1'b1, 32'h0000_0005);
    rd(IFD_OFS_FPST, 32'h0000_0005);
    bus(IFD_OFS_CMD, 1'b1, 32'h2);
    rd(IFD_OFS_CR, 32'h9500_0000);
    bus(IFD_OFS_OPA, 1'b1, 32'h0);
    bus(IFD_OFS_CMD, 1'b1, 32'h1);
    repeat (3) @(posedge clk);
    check("cr_port", 32'h2500_0000, cfr);
    close_out();
  end
endmodule

`default_nettype wire
